/* adcd_pkg.sv */
// Package for the axis direct command word decoder: offsets, bit positions,
// reset values and the synchronous feeding mode codes.
// Assumes a 16-bit register port addressed by word index.
`default_nettype none
package adcd_pkg;
    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int POS_W  = 32;

    // Register word indexes
    localparam logic [3:0] IDX_CMD      = 4'h0;
    localparam logic [3:0] IDX_CPOS_LO  = 4'h2;
    localparam logic [3:0] IDX_CPOS_HI  = 4'h3;
    localparam logic [3:0] IDX_IRQ_STAT = 4'h4;
    localparam logic [3:0] IDX_IRQ_MASK = 4'h5;
    localparam logic [3:0] IDX_FLAGS    = 4'h6;
    localparam logic [3:0] IDX_LPOS_LO  = 4'h7;
    localparam logic [3:0] IDX_LPOS_HI  = 4'h8;
    localparam logic [3:0] IDX_OPOS_LO  = 4'h9;
    localparam logic [3:0] IDX_OPOS_HI  = 4'hA;

    // Command word bit positions
    localparam int CB_ABS      = 0;
    localparam int CB_REL      = 1;
    localparam int CB_SPD      = 2;
    localparam int CB_INT_FEED = 5;
    localparam int CB_MASK_LAT = 6;
    localparam int CB_PRESET   = 7;
    localparam int CB_SYNC_POS = 8;
    localparam int CB_SYNC_VEL = 9;
    localparam int CB_SYNC_TRQ = 10;
    localparam int CB_ORG_EN   = 11;
    localparam int CB_ORG_CLR  = 14;
    localparam int CB_LAT_CLR  = 15;
    localparam int N_START     = 3;

    // Bits that store: unused positions are masked off and read as zero
    localparam logic [15:0] CMD_STORE_MASK = 16'hCFE7;

    // Interrupt status bit positions
    localparam int IRQ_START  = 0;
    localparam int IRQ_PRESET = 1;
    localparam int IRQ_LATCH  = 2;
    localparam int IRQ_ORIGIN = 3;
    localparam int N_IRQ      = 4;

    // Flag register bit positions
    localparam int F_LAT_DONE = 0;
    localparam int F_ORG_DONE = 1;
    localparam int F_MODE_LSB = 4;

    // Reset values
    localparam logic [15:0] CMD_RESET  = 16'h0000;
    localparam logic [3:0]  MASK_RESET = 4'h0;

    // Synchronous feeding mode, one-hot
    typedef enum logic [3:0] {
        ADCD_MODE_NONE = 4'b0001,
        ADCD_MODE_POS  = 4'b0010,
        ADCD_MODE_VEL  = 4'b0100,
        ADCD_MODE_TRQ  = 4'b1000
    } adcd_mode_t;
endpackage
`default_nettype wire

/* adcd_top.sv */
// Axis direct command word decoder: command word register, start and preset
// pulses, synchronous feeding mode, interrupt input and origin latches.
// Assumes a single-cycle register port and pins that need synchronising.
//
// How it works
// R1 - Rising bit 0, 1 or 2 gives an absolute, relative or speed start pulse.
// R2 - Bits 3, 4, 12 and 13 are left unused by the host; they store nothing.
// R3 - Bit 5 chooses interrupt feeding for the start that is issued.
// R4 - Bit 6 set enables the interrupt input mask for interrupt feeding.
// R5 - Bit 6 set also enables the present position latch on interrupt input.
// R6 - Rising bit 7 presets the present position with the command position.
// R7 - While bit 8 is set, the axis runs synchronous feeding position control.
// R8 - While bit 9 is set and bit 8 clear, synchronous feeding velocity without position loop.
// R9 - While bit 10 is set and bits 8 and 9 clear, the axis runs synchronous feeding torque control.
// R10 - Bit 11 enables the origin position latch.
// R11 - Bit 14 set clears the origin latch completed flag.
// R12 - Bit 15 set clears the latch completed flag.
// R13 - Clearing a mode bit leaves that mode; clear bits act only while set.
`default_nettype none
module adcd_top (
    // Clock and reset
    input  wire logic                      clk_sys_in,
    input  wire logic                      rstn_in,
    // Register port
    input  wire logic [adcd_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic [adcd_pkg::DATA_W-1:0] reg_wdata_in,
    input  wire logic                      reg_wr_in,
    input  wire logic                      reg_rd_in,
    output logic      [adcd_pkg::DATA_W-1:0] reg_rdata_out,
    // Axis position and pins
    input  wire logic [adcd_pkg::POS_W-1:0]  present_pos_in,
    input  wire logic                      intr_pin_in,
    input  wire logic                      origin_pin_in,
    // Motion controls
    output logic      [adcd_pkg::N_START-1:0] start_pulse_out,
    output logic                           int_feed_out,
    output logic                           intr_mask_en_out,
    output logic                           preset_pulse_out,
    output logic      [adcd_pkg::POS_W-1:0]  preset_value_out,
    output logic      [3:0]                sync_mode_out,
    // Status and interrupt
    output logic                           latch_done_out,
    output logic                           origin_done_out,
    output logic                           irq_out
);
    import adcd_pkg::*;

    // Whole module state
    typedef struct packed {
        logic [DATA_W-1:0] cmd;
        logic [DATA_W-1:0] cmd_prev;
        logic [POS_W-1:0]  cpos;
        logic [N_IRQ-1:0]  irq_stat;
        logic [N_IRQ-1:0]  irq_mask;
        logic              lat_done;
        logic              org_done;
        logic [POS_W-1:0]  lpos;
        logic [POS_W-1:0]  opos;
        logic [1:0]        intr_sync;
        logic              intr_prev;
        logic [1:0]        org_sync;
        logic              org_prev;
        logic [N_START-1:0] start;
        logic              int_feed;
        logic              mask_en;
        logic              preset;
        logic [POS_W-1:0]  preset_val;
        adcd_mode_t        mode;
        logic [DATA_W-1:0] rdata;
        logic              irq;
    } adcd_state_t;

    adcd_state_t state_reg;
    adcd_state_t state_next;

    // Rising edge of a level against its value one cycle earlier
    function automatic logic adcd_rose(input logic cur, input logic prev);
        adcd_rose = cur & ~prev;
    endfunction

    // Mode from the level-held feeding bits; the lower bit wins if several
    function automatic adcd_mode_t adcd_mode_sel(input logic [DATA_W-1:0] w);
        if (w[CB_SYNC_POS]) begin
            adcd_mode_sel = ADCD_MODE_POS; // R7
        end else if (w[CB_SYNC_VEL]) begin
            adcd_mode_sel = ADCD_MODE_VEL; // R8
        end else if (w[CB_SYNC_TRQ]) begin
            adcd_mode_sel = ADCD_MODE_TRQ; // R9
        end else begin
            adcd_mode_sel = ADCD_MODE_NONE; // R13
        end
    endfunction

    // Next-state logic
    always_comb begin
        logic [N_IRQ-1:0] ev;
        logic [N_IRQ-1:0] w1c;
        logic             intr_rise;
        logic             org_rise;
        logic             lat_set;
        logic             org_set;
        logic             preset_rise;
        logic             any_start;
        ev          = '0;
        w1c         = '0;
        intr_rise   = 1'b0;
        org_rise    = 1'b0;
        lat_set     = 1'b0;
        org_set     = 1'b0;
        preset_rise = 1'b0;
        any_start   = 1'b0;
        state_next  = state_reg;

        // Register writes
        if (reg_wr_in) begin
            if (reg_addr_in == IDX_CMD) begin
                state_next.cmd = reg_wdata_in & CMD_STORE_MASK; // R2
            end else if (reg_addr_in == IDX_CPOS_LO) begin
                state_next.cpos[DATA_W-1:0] = reg_wdata_in;
            end else if (reg_addr_in == IDX_CPOS_HI) begin
                state_next.cpos[POS_W-1:DATA_W] = reg_wdata_in;
            end else if (reg_addr_in == IDX_IRQ_STAT) begin
                w1c = reg_wdata_in[N_IRQ-1:0];
            end else if (reg_addr_in == IDX_IRQ_MASK) begin
                state_next.irq_mask = reg_wdata_in[N_IRQ-1:0];
            end
        end

        // Edges of the stored command word, one cycle after the write
        state_next.cmd_prev = state_reg.cmd;
        for (int i = 0; i < N_START; i++) begin
            state_next.start[i] = adcd_rose(state_reg.cmd[CB_ABS + i],
                                            state_reg.cmd_prev[CB_ABS + i]); // R1
            any_start = any_start | state_next.start[i];
        end
        // Feeding choice is caught with the start, held until the next one
        if (any_start) begin
            state_next.int_feed = state_reg.cmd[CB_INT_FEED]; // R3
        end
        state_next.mask_en = state_reg.cmd[CB_MASK_LAT]; // R4

        // Present position preset
        preset_rise = adcd_rose(state_reg.cmd[CB_PRESET], state_reg.cmd_prev[CB_PRESET]);
        state_next.preset = preset_rise; // R6
        if (preset_rise) begin
            state_next.preset_val = state_reg.cpos; // R6
        end

        // Level-held synchronous feeding mode
        state_next.mode = adcd_mode_sel(state_reg.cmd);

        // Pin synchronisers; only the second stage is looked at
        state_next.intr_sync = {state_reg.intr_sync[0], intr_pin_in};
        state_next.org_sync  = {state_reg.org_sync[0], origin_pin_in};
        state_next.intr_prev = state_reg.intr_sync[1];
        state_next.org_prev  = state_reg.org_sync[1];
        intr_rise = adcd_rose(state_reg.intr_sync[1], state_reg.intr_prev);
        org_rise  = adcd_rose(state_reg.org_sync[1], state_reg.org_prev);

        // Present position latch on the interrupt input
        lat_set = intr_rise & state_reg.cmd[CB_MASK_LAT]; // R5
        if (lat_set) begin
            state_next.lpos = present_pos_in;
        end
        // Origin position latch
        org_set = org_rise & state_reg.cmd[CB_ORG_EN]; // R10
        if (org_set) begin
            state_next.opos = present_pos_in;
        end

        // Completed flags: a new latch outranks a clear held in the same cycle
        if (lat_set) begin
            state_next.lat_done = 1'b1;
        end else if (state_reg.cmd[CB_LAT_CLR]) begin
            state_next.lat_done = 1'b0; // R12
        end
        if (org_set) begin
            state_next.org_done = 1'b1;
        end else if (state_reg.cmd[CB_ORG_CLR]) begin
            state_next.org_done = 1'b0; // R11
        end

        // Sticky interrupt status, set wins over write-one-to-clear
        ev[IRQ_START]  = any_start;
        ev[IRQ_PRESET] = preset_rise;
        ev[IRQ_LATCH]  = lat_set;
        ev[IRQ_ORIGIN] = org_set;
        state_next.irq_stat = (state_reg.irq_stat & ~w1c) | ev;
        state_next.irq = |(state_next.irq_stat & state_next.irq_mask);

        // Read data, valid in the cycle after the read strobe only
        state_next.rdata = '0;
        if (reg_rd_in) begin
            if (reg_addr_in == IDX_CMD) begin
                state_next.rdata = state_reg.cmd;
            end else if (reg_addr_in == IDX_CPOS_LO) begin
                state_next.rdata = state_reg.cpos[DATA_W-1:0];
            end else if (reg_addr_in == IDX_CPOS_HI) begin
                state_next.rdata = state_reg.cpos[POS_W-1:DATA_W];
            end else if (reg_addr_in == IDX_IRQ_STAT) begin
                state_next.rdata = {{(DATA_W-N_IRQ){1'b0}}, state_reg.irq_stat};
            end else if (reg_addr_in == IDX_IRQ_MASK) begin
                state_next.rdata = {{(DATA_W-N_IRQ){1'b0}}, state_reg.irq_mask};
            end else if (reg_addr_in == IDX_FLAGS) begin
                state_next.rdata[F_LAT_DONE] = state_reg.lat_done;
                state_next.rdata[F_ORG_DONE] = state_reg.org_done;
                state_next.rdata[F_MODE_LSB +: $bits(adcd_mode_t)] = state_reg.mode;
            end else if (reg_addr_in == IDX_LPOS_LO) begin
                state_next.rdata = state_reg.lpos[DATA_W-1:0];
            end else if (reg_addr_in == IDX_LPOS_HI) begin
                state_next.rdata = state_reg.lpos[POS_W-1:DATA_W];
            end else if (reg_addr_in == IDX_OPOS_LO) begin
                state_next.rdata = state_reg.opos[DATA_W-1:0];
            end else if (reg_addr_in == IDX_OPOS_HI) begin
                state_next.rdata = state_reg.opos[POS_W-1:DATA_W];
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg          <= '0;
            state_reg.cmd      <= CMD_RESET;
            state_reg.cmd_prev <= CMD_RESET;
            state_reg.irq_mask <= MASK_RESET;
            state_reg.mode     <= ADCD_MODE_NONE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_out    = state_reg.rdata;
    assign start_pulse_out  = state_reg.start;
    assign int_feed_out     = state_reg.int_feed;
    assign intr_mask_en_out = state_reg.mask_en;
    assign preset_pulse_out = state_reg.preset;
    assign preset_value_out = state_reg.preset_val;
    assign sync_mode_out    = state_reg.mode;
    assign latch_done_out   = state_reg.lat_done;
    assign origin_done_out  = state_reg.org_done;
    assign irq_out          = state_reg.irq;
endmodule
`default_nettype wire

/* adcd_asserts.sv */
// Port checker for the command word decoder.
// Assumes the bench keeps a pin quiet while a clear bit is tested.
`default_nettype none
module adcd_asserts
    import adcd_pkg::*;
(
    // Clock, reset and register port
    input wire logic        clk_sys_in,
    input wire logic        rstn_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    // Pins and outputs
    input wire logic        intr_pin_in,
    input wire logic        origin_pin_in,
    input wire logic [2:0]  start_pulse_out,
    input wire logic        intr_mask_en_out,
    input wire logic        preset_pulse_out,
    input wire logic [3:0]  sync_mode_out,
    input wire logic        latch_done_out,
    input wire logic        origin_done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cmd_reg;
    logic [7:0]  ih_reg, oh_reg, lh_reg, eh_reg;

    // Shadow of the command word and short histories of pins and enables
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_reg <= 16'h0000;
            ih_reg <= 8'h00;
            oh_reg <= 8'h00;
            lh_reg <= 8'h00;
            eh_reg <= 8'h00;
        end else begin
            if (reg_wr_in && reg_addr_in == IDX_CMD) begin
                cmd_reg <= reg_wdata_in & CMD_STORE_MASK;
            end
            ih_reg <= {ih_reg[6:0], intr_pin_in};
            oh_reg <= {oh_reg[6:0], origin_pin_in};
            lh_reg <= {lh_reg[6:0], cmd_reg[6]};
            eh_reg <= {eh_reg[6:0], cmd_reg[11]};
        end
    end

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    start_pulse_a: assert property (
        start_pulse_out == ($past(cmd_reg[2:0]) & ~$past(cmd_reg[2:0], 2)))
        else $error("start pulse not on rising bit");
    mask_copy_a: assert property (intr_mask_en_out == $past(cmd_reg[6]))
        else $error("mask enable wrong");
    preset_edge_a: assert property (
        preset_pulse_out == ($past(cmd_reg[7]) && !$past(cmd_reg[7], 2)))
        else $error("preset pulse wrong");
    mode_pos_a: assert property ($past(cmd_reg[8]) |-> sync_mode_out == ADCD_MODE_POS)
        else $error("position mode missing");
    mode_vel_a: assert property (
        $past(cmd_reg[9:8]) == 2'h2 |-> sync_mode_out == ADCD_MODE_VEL)
        else $error("velocity mode missing");
    mode_trq_a: assert property (
        $past(cmd_reg[10:8]) == 3'h4 |-> sync_mode_out == ADCD_MODE_TRQ)
        else $error("torque mode missing");
    latch_gate_a: assert property ($rose(latch_done_out) |-> lh_reg != 8'h00)
        else $error("latch done without enable");
    origin_gate_a: assert property ($rose(origin_done_out) |-> eh_reg != 8'h00)
        else $error("origin done without enable");
    latch_clear_a: assert property (
        $past(cmd_reg[15]) && ih_reg == 8'h00 |-> !latch_done_out)
        else $error("latch flag not cleared");
    origin_clear_a: assert property (
        $past(cmd_reg[14]) && oh_reg == 8'h00 |-> !origin_done_out)
        else $error("origin flag not cleared");
endmodule
`default_nettype wire

/* adcd_axis_model.sv */
// Axis side model: a moving present position and the two input pins.
// Assumes a one-cycle request from the bench for each pin pulse.
`default_nettype none
module adcd_axis_model (
    // Clock, reset and requests
    input  wire logic        clk_sys_in,
    input  wire logic        rstn_in,
    input  wire logic        fire_intr_in,
    input  wire logic        fire_org_in,
    // Axis outputs
    output logic      [31:0] pos_out,
    output logic             intr_pin_out,
    output logic             org_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ic_reg, oc_reg;

    // Pins stay high four cycles so the synchronisers cannot miss them
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pos_out <= 32'h0000_0000;
            ic_reg <= 3'h0;
            oc_reg <= 3'h0;
        end else begin
            pos_out <= pos_out + 32'h0000_0003;
            ic_reg <= fire_intr_in ? 3'h4 : ic_reg - {2'h0, ic_reg != 3'h0};
            oc_reg <= fire_org_in ? 3'h4 : oc_reg - {2'h0, oc_reg != 3'h0};
        end
    end
    assign intr_pin_out = (ic_reg != 3'h0);
    assign org_pin_out = (oc_reg != 3'h0);
endmodule
`default_nettype wire

/* tb_top.sv */
// Bench for the command word decoder: register tasks and directed tests.
// Assumes the axis model supplies position and pin pulses.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adcd_pkg::*;
    logic clk_sys_in = 1'b0, rstn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic fi = 1'b0, fo = 1'b0, intr_pin_in, origin_pin_in;
    logic [3:0]  reg_addr_in = 4'h0, sync_mode_out;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, en;
    logic [31:0] present_pos_in, preset_value_out, p;
    logic [2:0]  start_pulse_out;
    logic int_feed_out, intr_mask_en_out, preset_pulse_out;
    logic latch_done_out, origin_done_out, irq_out;
    int err_count = 0, num_checks = 0;

    adcd_top DUT (.clk_sys_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .present_pos_in, .intr_pin_in, .origin_pin_in,
        .start_pulse_out, .int_feed_out, .intr_mask_en_out, .preset_pulse_out,
        .preset_value_out, .sync_mode_out, .latch_done_out, .origin_done_out, .irq_out);
    adcd_axis_model u_axis (.clk_sys_in, .rstn_in, .fire_intr_in(fi), .fire_org_in(fo),
        .pos_out(present_pos_in), .intr_pin_out(intr_pin_in), .org_pin_out(origin_pin_in));

    // Clock and watchdog; the tests need well under a thousand cycles
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #100000;
        err_count++;
        print_verdict();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    // Read data exist only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, exp);
    endtask
    task automatic fire(input int j);
        @(posedge clk_sys_in);
        fi <= (j == 0);
        fo <= (j == 1);
        @(posedge clk_sys_in);
        fi <= 1'b0;
        fo <= 1'b0;
        // Pin is seen two edges after its first sample; position steps by three
        #1 p = present_pos_in + 32'h0000_0006;
    endtask
    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        rd(IDX_CMD, 16'h0000);
        rd(IDX_IRQ_MASK, 16'h0000);
        chk(sync_mode_out, ADCD_MODE_NONE);
        rd(4'hF, 16'h0000);
        // Every start kind, feeding on for the first three
        for (int i = 0; i < 6; i++) begin
            wr(IDX_CMD, (i < 3 ? 16'h0020 : 16'h0000) | (16'h0001 << (i % 3)));
            tick(1);
            chk(start_pulse_out, 32'h1 << (i % 3));
            tick(1);
            chk(start_pulse_out, 32'h0);
            chk(int_feed_out, i < 3);
            wr(IDX_CMD, 16'h0000);
        end
        // Unused bits left clear by the host; position mode wins
        wr(IDX_CMD, 16'hCFE7);
        rd(IDX_CMD, 16'hCFE7);
        chk(sync_mode_out, ADCD_MODE_POS);
        chk(intr_mask_en_out, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_CMD, i < 3 ? 16'h0100 << i : 16'h0000);
            tick(1);
            chk(sync_mode_out, i < 3 ? 32'h2 << i : 32'h1);
        end
        // Preset raises only the unmasked-in interrupt; older events cleared first
        wr(IDX_IRQ_STAT, 16'h000F);
        wr(IDX_IRQ_MASK, 16'h0002);
        tick(1);
        chk(irq_out, 1'b0);
        wr(IDX_CPOS_LO, 16'h5A3C);
        wr(IDX_CPOS_HI, 16'h8001);
        wr(IDX_CMD, 16'h0080);
        tick(1);
        chk(preset_pulse_out, 1'b1);
        chk(preset_value_out, 32'h8001_5A3C);
        tick(2);
        chk(preset_pulse_out, 1'b0);
        chk(irq_out, 1'b1);
        rd(IDX_IRQ_STAT, 16'h0002);
        wr(IDX_IRQ_STAT, 16'h0002);
        tick(2);
        chk(irq_out, 1'b0);
        // Latch and origin: disabled, enabled, then cleared
        for (int j = 0; j < 2; j++) begin
            en = j ? 16'h0800 : 16'h0040;
            wr(IDX_CMD, 16'h0000);
            fire(j);
            tick(8);
            chk(j ? origin_done_out : latch_done_out, 1'b0);
            wr(IDX_CMD, en);
            fire(j);
            tick(8);
            chk(j ? origin_done_out : latch_done_out, 1'b1);
            chk(intr_mask_en_out, j == 0);
            rd(IDX_FLAGS, j ? 16'h0012 : 16'h0011);
            rd(j ? IDX_OPOS_LO : IDX_LPOS_LO, p[15:0]);
            rd(j ? IDX_OPOS_HI : IDX_LPOS_HI, p[31:16]);
            rd(IDX_IRQ_STAT, j ? 16'h000C : 16'h0004);
            wr(IDX_CMD, en | (j ? 16'h4000 : 16'h8000));
            tick(1);
            chk(j ? origin_done_out : latch_done_out, 1'b0);
        end
        print_verdict();
    end
endmodule

bind adcd_top adcd_asserts u_chk (.clk_sys_in, .rstn_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .intr_pin_in, .origin_pin_in, .start_pulse_out, .intr_mask_en_out,
    .preset_pulse_out, .sync_mode_out, .latch_done_out, .origin_done_out);
`default_nettype wire
